// ### rtl/vmg_top.sv
/*
  control register group of a mono class-D amplifier: volume ramp speed,
  mute, frame slot pick, 9-bit digital level, switching ratio and output
  gain, reached over an APB slave.
  assumes: i_frame_clk is the frame word clock pin, asynchronous to i_clk;
  i_shutdown, i_sleep and i_dev_id come from logic on i_clk.
*/
`timescale 1ns/1ns
`include "vmg_regs.svh"

module vmg_top (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // audio side
  input  wire logic              i_frame_clk,
  input  wire logic              i_shutdown,
  input  wire logic              i_sleep,
  input  wire logic [2:0]        i_dev_id,
  // steering outputs
  output logic [8:0]             o_level_code,
  output logic signed [9:0]      o_level_qdb,
  output logic                   o_idle_audio,
  output logic [2:0]             o_play_slot,
  output logic [4:0]             o_pwm_ratio,
  output logic [1:0]             o_gain_sel
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // upper address bits must be zero: aliases are refused, not folded
  function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
    hits = (addr[11:10] == 2'h0) && (addr[9:2] == idx[7:0]) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hits(addr, `VMG_IDX_CTRL) || hits(addr, `VMG_IDX_RAMP) || hits(addr, `VMG_IDX_VOL) ||
             hits(addr, `VMG_IDX_ANA) || hits(addr, `VMG_IDX_LSB) || hits(addr, `VMG_IDX_STAT);
  endfunction

  // single speed ratios 6..24; double speed halves each
  // the ratio is only reported; the switching stage lies outside this block
  function automatic logic [4:0] ratio_of(input logic [2:0] code, input logic dbl);
    logic [4:0] r;
    r = 5'h00;
    unique case (code)
      3'h0: r = 5'h06;
      3'h1: r = 5'h08;
      3'h2: r = 5'h0a;
      3'h3: r = 5'h0c;
      3'h4: r = 5'h0e;
      3'h5: r = 5'h10;
      3'h6: r = 5'h14;
      3'h7: r = 5'h18;
    endcase
    ratio_of = dbl ? {1'b0, r[4:1]} : r;
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic [7:0]          ramp_q, ramp_d;
  logic [7:0]          vol_q, vol_d;
  logic [7:0]          ana_q, ana_d;
  logic                slot_src_q, slot_src_d;
  logic                speed_q, speed_d;
  logic                lsb_q, lsb_d;
  logic [31:0]         prdata_q, prdata_d;
  logic                pslverr_q, pslverr_d;
  logic                frm_s1_q, frm_s2_q, frm_s3_q;
  logic [8:0]          target_q, target_d;
  logic [2:0]          slot_q, slot_d;
  logic [4:0]          ratio_q, ratio_d;
  logic signed [9:0]   qdb_q, qdb_d;
  logic                idle_q, idle_d;

  vmg_pkg::vmg_cfg_s   cfg;
  vmg_pkg::vmg_ramp_e  ramp_state;
  logic [8:0]          live_level;
  logic                frame_tick;
  logic                wr_en;
  logic                setup;
  logic                mute_eff;
  logic [9:0]          rel_code;

  // ----------------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------------
  // zero wait: every register is a flop, so no access ever needs a stall
  assign o_pready = 1'b1;
  assign wr_en    = i_psel && i_penable && o_pready;
  assign setup    = i_psel && !i_penable;

  // ----------------------------------------------------------------------
  // register writes and apb read data
  // ----------------------------------------------------------------------
  always_comb begin
    ramp_d     = ramp_q;
    vol_d      = vol_q;
    ana_d      = ana_q;
    slot_src_d = slot_src_q;
    speed_d    = speed_q;
    lsb_d      = lsb_q;
    prdata_d   = prdata_q;
    pslverr_d  = pslverr_q;
    // reserved bits of RAMP, VOL and ANA are stored as written; CTRL and LSB keep only their defined bits
    if (wr_en && i_pwrite) begin
      if (hits(i_paddr, `VMG_IDX_RAMP)) begin
        ramp_d = i_pwdata[7:0];
      end
      if (hits(i_paddr, `VMG_IDX_VOL)) begin
        vol_d = i_pwdata[7:0];
      end
      if (hits(i_paddr, `VMG_IDX_ANA)) begin
        ana_d = i_pwdata[7:0];
      end
      if (hits(i_paddr, `VMG_IDX_CTRL)) begin
        slot_src_d = i_pwdata[`VMG_CTRL_SLOT_SRC];
        speed_d    = i_pwdata[`VMG_CTRL_SPEED];
      end
      if (hits(i_paddr, `VMG_IDX_LSB)) begin
        lsb_d = i_pwdata[`VMG_LSB_BIT];
      end
    end
    // answer prepared in the setup cycle so zero-wait reads come from flops
    // unmapped reads answer zero and flag pslverr in the access phase
    if (setup) begin
      pslverr_d = !mapped(i_paddr);
      prdata_d  = 32'h0000_0000;
      if (!i_pwrite) begin
        if (hits(i_paddr, `VMG_IDX_RAMP)) begin
          prdata_d[7:0] = ramp_q;
        end
        if (hits(i_paddr, `VMG_IDX_VOL)) begin
          prdata_d[7:0] = vol_q;
        end
        if (hits(i_paddr, `VMG_IDX_ANA)) begin
          prdata_d[7:0] = ana_q;
        end
        if (hits(i_paddr, `VMG_IDX_CTRL)) begin
          prdata_d[`VMG_CTRL_SLOT_SRC] = slot_src_q;
          prdata_d[`VMG_CTRL_SPEED]    = speed_q;
        end
        if (hits(i_paddr, `VMG_IDX_LSB)) begin
          prdata_d[`VMG_LSB_BIT] = lsb_q;
        end
        if (hits(i_paddr, `VMG_IDX_STAT)) begin
          prdata_d[8:0]   = live_level;
          prdata_d[10:9]  = ramp_state;
          prdata_d[11]    = idle_q;
          prdata_d[14:12] = slot_q;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ramp_q     <= `VMG_RST_RAMP;
      vol_q      <= `VMG_RST_VOL;
      ana_q      <= `VMG_RST_ANA;
      slot_src_q <= 1'b0;
      speed_q    <= 1'b0;
      lsb_q      <= `VMG_RST_LSB;
      prdata_q   <= 32'h0000_0000;
      pslverr_q  <= 1'b0;
    end else begin
      ramp_q     <= ramp_d;
      vol_q      <= vol_d;
      ana_q      <= ana_d;
      slot_src_q <= slot_src_d;
      speed_q    <= speed_d;
      lsb_q      <= lsb_d;
      prdata_q   <= prdata_d;
      pslverr_q  <= pslverr_d;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pslverr = pslverr_q & wr_en;

  // ----------------------------------------------------------------------
  // configuration view
  // ----------------------------------------------------------------------
  always_comb begin
    cfg.ramp_fast  = ramp_q[`VMG_RAMP_SPEED];
    cfg.mute       = ramp_q[`VMG_RAMP_MUTE];
    cfg.slot_pick  = ramp_q[`VMG_RAMP_SLOT_LO +: 3];
    cfg.slot_src   = slot_src_q;
    cfg.speed_dbl  = speed_q;
    cfg.level_code = {vol_q, lsb_q};
    cfg.pwm_code   = ana_q[`VMG_ANA_PWM_LO +: 3];
    cfg.gain_sel   = ana_q[`VMG_ANA_GAIN_LO +: 2];
  end

  // ----------------------------------------------------------------------
  // frame word clock synchroniser
  // ----------------------------------------------------------------------
  // two flops settle the pin; the third only feeds the edge detector
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      frm_s1_q <= 1'b0;
      frm_s2_q <= 1'b0;
      frm_s3_q <= 1'b0;
    end else begin
      frm_s1_q <= i_frame_clk;
      frm_s2_q <= frm_s1_q;
      frm_s3_q <= frm_s2_q;
    end
  end

  // one pulse per frame period on the rising edge
  assign frame_tick = frm_s2_q && !frm_s3_q;

  // ----------------------------------------------------------------------
  // steering: target, slot, ratio, level mapping
  // ----------------------------------------------------------------------
  // shutdown and sleep share the mute path, so every cause ramps the same way
  assign mute_eff = cfg.mute || (cfg.level_code < `VMG_MUTE_BELOW) ||
                    i_shutdown || i_sleep;

  always_comb begin
    // muting ramps to full attenuation, unmuting ramps back to the programmed code
    target_d = mute_eff ? 9'h000 : cfg.level_code;
    slot_d   = cfg.slot_src ? cfg.slot_pick : i_dev_id;
    if (!cfg.slot_src) begin
      slot_d = i_dev_id;
    end
    ratio_d  = ratio_of(cfg.pwm_code, cfg.speed_dbl);
    // idle audio only once the level has reached the bottom; the target must
    // be at zero too, or a step on the same edge would lift the level again
    idle_d   = mute_eff && (live_level == 9'h000) && (target_q == 9'h000);
    // the quarter dB view lags the live level by one cycle
    rel_code = {1'b0, live_level} - `VMG_ZERO_DB_CODE;
    // code step is one quarter dB; the floor sits at -100 dB
    if ($signed(rel_code) < $signed(`VMG_MIN_QDB)) begin
      qdb_d = $signed(`VMG_MIN_QDB);
    end else begin
      qdb_d = $signed(rel_code);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      target_q <= {`VMG_RST_VOL, `VMG_RST_LSB};
      slot_q   <= 3'h0;
      ratio_q  <= 5'h10;
      qdb_q    <= 10'sh000;
      idle_q   <= 1'b0;
    end else begin
      target_q <= target_d;
      slot_q   <= slot_d;
      ratio_q  <= ratio_d;
      qdb_q    <= qdb_d;
      idle_q   <= idle_d;
    end
  end

  // ----------------------------------------------------------------------
  // ramp engine
  // ----------------------------------------------------------------------
  vmg_ramp u_ramp (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_frame_tick (frame_tick),
    .i_fast       (cfg.ramp_fast),
    .i_target     (target_q),
    .o_level      (live_level),
    .o_state      (ramp_state)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_level_code = live_level;
  assign o_level_qdb  = qdb_q;
  assign o_idle_audio = idle_q;
  assign o_play_slot  = slot_q;
  assign o_pwm_ratio  = ratio_q;
  assign o_gain_sel   = ana_q[`VMG_ANA_GAIN_LO +: 2];

endmodule // vmg_top

// ### rtl/vmg_regs.svh
/*
  register indices, field positions, reset values and ramp pacing counts
  for the volume, mute, switching ratio and output gain control block.
  assumes: included by bare name; definitions only.
*/
`ifndef VMG_REGS_SVH
`define VMG_REGS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define VMG_IDX_CTRL        8'h02
`define VMG_IDX_RAMP        8'h03
`define VMG_IDX_VOL         8'h04
`define VMG_IDX_ANA         8'h06
`define VMG_IDX_LSB         8'h13
`define VMG_IDX_STAT        8'h20

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VMG_CTRL_SLOT_SRC   6
`define VMG_CTRL_SPEED      3
`define VMG_RAMP_SPEED      6
`define VMG_RAMP_MUTE       4
`define VMG_RAMP_SLOT_LO    0
`define VMG_ANA_PWM_LO      4
`define VMG_ANA_GAIN_LO     2
`define VMG_LSB_BIT         0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define VMG_RST_RAMP        8'h80
`define VMG_RST_VOL         8'hcf
`define VMG_RST_ANA         8'h55
`define VMG_RST_LSB         1'h1

// ----------------------------------------------------------------------
// level code constants and ramp pacing
// ----------------------------------------------------------------------
`define VMG_MUTE_BELOW      9'h008
`define VMG_ZERO_DB_CODE    10'h19f
`define VMG_MIN_QDB         10'h270
`define VMG_SLOW_FRAMES     3'h7

`endif

// ### rtl/vmg_pkg.sv
/*
  types shared by the volume/mute/gain control block.
  assumes: compiled before the design modules.
*/
package vmg_pkg;

  typedef enum logic [1:0] {
    RAMP_HOLD = 2'b00,
    RAMP_DOWN = 2'b01,
    RAMP_UP   = 2'b10
  } vmg_ramp_e;

  typedef struct packed {
    logic       ramp_fast;
    logic       mute;
    logic [2:0] slot_pick;
    logic       slot_src;
    logic       speed_dbl;
    logic [8:0] level_code;
    logic [2:0] pwm_code;
    logic [1:0] gain_sel;
  } vmg_cfg_s;

endpackage

// ### rtl/vmg_ramp.sv
/*
  volume ramp: walks the live level code one step at a time toward a target,
  paced by frame word clock periods.
  assumes: i_frame_tick is a one-cycle pulse per frame, on i_clk.
*/
`timescale 1ns/1ns
`include "vmg_regs.svh"

module vmg_ramp (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // pacing and target
  input  wire logic              i_frame_tick,
  input  wire logic              i_fast,
  input  wire logic [8:0]        i_target,
  // live level and ramp state
  output logic [8:0]             o_level,
  output vmg_pkg::vmg_ramp_e     o_state
);

  logic [2:0]          pace_q, pace_d;
  logic [8:0]          level_q, level_d;
  vmg_pkg::vmg_ramp_e  state_q, state_d;
  logic                step_now;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    pace_d   = pace_q;
    level_d  = level_q;
    step_now = 1'b0;
    if (i_frame_tick) begin
      // one step per frame when fast, else one per eight frames
      if (i_fast || pace_q == `VMG_SLOW_FRAMES) begin
        pace_d   = 3'h0;
        step_now = 1'b1;
      end else begin
        pace_d = pace_q + 3'h1;
      end
    end
    if (level_q > i_target) begin
      state_d = vmg_pkg::RAMP_DOWN;
    end else if (level_q < i_target) begin
      state_d = vmg_pkg::RAMP_UP;
    end else begin
      state_d = vmg_pkg::RAMP_HOLD;
    end
    unique case (state_d)
      vmg_pkg::RAMP_DOWN: begin
        if (step_now) begin
          level_d = level_q - 9'h001;
        end
      end
      vmg_pkg::RAMP_UP: begin
        if (step_now) begin
          level_d = level_q + 9'h001;
        end
      end
      vmg_pkg::RAMP_HOLD: begin
        // idle prescaler restarts so the first step of a new ramp waits a full period
        pace_d = 3'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pace_q  <= 3'h0;
      level_q <= {`VMG_RST_VOL, `VMG_RST_LSB};
      state_q <= vmg_pkg::RAMP_HOLD;
    end else begin
      pace_q  <= pace_d;
      level_q <= level_d;
      state_q <= state_d;
    end
  end

  assign o_level = level_q;
  assign o_state = state_q;

endmodule // vmg_ramp

// ### dv/vmg_top_props.sv
/*
  concurrent checks on the ports of the volume/mute/gain control block.
  assumes: one clock, synchronous active-low reset held at least two edges.
*/
`timescale 1ns/1ns

module vmg_top_props (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // watched signals
  input  wire logic              i_frame_clk,
  input  wire logic              o_pslverr,
  input  wire logic [8:0]        o_level_code,
  input  wire logic signed [9:0] o_level_qdb,
  input  wire logic              o_idle_audio,
  input  wire logic [4:0]        o_pwm_ratio,
  input  wire logic [1:0]        o_gain_sel
);
  // ----------------------------------------------------------------------
  // frame edge history: a level step needs a frame rise two to six edges ago
  // ----------------------------------------------------------------------
  logic [6:0] fr_q;
  always_ff @(posedge i_clk) fr_q <= {fr_q[5:0], i_frame_clk};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_step;
    $changed(o_level_code) |-> (o_level_code == $past(o_level_code) + 9'h001) ||
                               (o_level_code == $past(o_level_code) - 9'h001);
  endproperty
  a_step: assert property (p_step) else $error("level moved more than one code");
  property p_pace;
    $changed(o_level_code) |-> |(fr_q[5:1] & ~fr_q[6:2]);
  endproperty
  a_pace: assert property (p_pace) else $error("level moved without a frame");
  property p_qdb;
    o_level_qdb == (($past(o_level_code) < 9'h00f) ? -10'sh190 :
                    $signed({1'b0, $past(o_level_code)}) - 10'sh19f);
  endproperty
  a_qdb: assert property (p_qdb) else $error("quarter dB level wrong");
  property p_idle;
    o_idle_audio |-> o_level_code == 9'h000;
  endproperty
  a_idle: assert property (p_idle) else $error("idle audio with level above zero");
  property p_ratio;
    o_pwm_ratio inside {5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
  endproperty
  a_ratio: assert property (p_ratio) else $error("illegal switching ratio");
  property p_rst_vol;
    $rose(i_rst_n) |-> o_level_code == 9'h19f && o_level_qdb == 10'sh000;
  endproperty
  a_rst_vol: assert property (p_rst_vol) else $error("level not 0 dB after reset");
  property p_rst_ratio;
    $rose(i_rst_n) |-> o_pwm_ratio == 5'h10;
  endproperty
  a_rst_ratio: assert property (p_rst_ratio) else $error("ratio not 16 after reset");
  property p_rst_gain;
    $rose(i_rst_n) |-> o_gain_sel == 2'h1;
  endproperty
  a_rst_gain: assert property (p_rst_gain) else $error("gain not 01 after reset");

  c_idle: cover property ($rose(o_idle_audio));
  c_up:   cover property ($changed(o_level_code) && o_level_code > $past(o_level_code));
  c_err:  cover property (o_pslverr);
endmodule // vmg_top_props

bind vmg_top vmg_top_props u_props (
  .i_clk,
  .i_rst_n,
  .i_frame_clk,
  .o_pslverr,
  .o_level_code,
  .o_level_qdb,
  .o_idle_audio,
  .o_pwm_ratio,
  .o_gain_sel
);

// ### dv/testbench.sv
/*
  self-checking bench for the volume/mute/gain control block over apb.
  assumes: apb slave that answers with pready; frame clock made here at 1/16 of i_clk.
*/
`timescale 1ns/1ns
`include "vmg_regs.svh"

module testbench;
  logic        i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_frame_clk = 0, i_shutdown = 0, i_sleep = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0;
  logic [2:0]  i_dev_id = 3'h3;
  logic [31:0] o_prdata, rd;
  logic        o_pready, o_pslverr, o_idle_audio, er;
  logic [8:0]  o_level_code;
  logic signed [9:0] o_level_qdb;
  logic [2:0]  o_play_slot;
  logic [4:0]  o_pwm_ratio;
  logic [1:0]  o_gain_sel;
  int          fail_count = 0, compares = 0, fc = 0, g;
  localparam int RAT[8] = '{6, 8, 10, 12, 14, 16, 20, 24};
  localparam logic [11:0] A_CTRL = {2'h0, `VMG_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_RAMP = {2'h0, `VMG_IDX_RAMP, 2'h0};
  localparam logic [11:0] A_VOL  = {2'h0, `VMG_IDX_VOL, 2'h0};
  localparam logic [11:0] A_ANA  = {2'h0, `VMG_IDX_ANA, 2'h0};
  localparam logic [11:0] A_LSB  = {2'h0, `VMG_IDX_LSB, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, `VMG_IDX_STAT, 2'h0};

  vmg_top dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_frame_clk, .i_shutdown, .i_sleep, .i_dev_id,
    .o_level_code, .o_level_qdb, .o_idle_audio, .o_play_slot, .o_pwm_ratio, .o_gain_sel);

  initial forever #10 i_clk = ~i_clk;
  // free-running frame clock, period 16 cycles
  always @(posedge i_clk) begin
    fc <= (fc == 7) ? 0 : fc + 1;
    if (fc == 7) i_frame_clk <= ~i_frame_clk;
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("mismatch at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  // request held until the edge at which pready is seen high; answer taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) begin
      n++;
      tmo(n, 50);
      @(posedge i_clk);
    end
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wait_lvl(input logic [8:0] e, input int lim);
    int n;
    n = 0;
    while (o_level_code !== e) begin
      n++;
      tmo(n, lim);
      @(negedge i_clk);
    end
  endtask
  // cycles between two later level steps
  task automatic step_gap(output int gap);
    logic [8:0] l;
    for (int k = 0; k < 2; k++) begin
      l = o_level_code;
      gap = 0;
      while (o_level_code === l) begin
        gap++;
        tmo(gap, 400);
        @(negedge i_clk);
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(32'(o_level_code), 32'h19f);
    chk(32'(o_pwm_ratio), 32'h10);
    chk(32'(o_gain_sel), 32'h1);
    chk(32'(o_idle_audio), 32'h0);
    rchk(A_RAMP, 32'h80);
    rchk(A_VOL, 32'hcf);
    rchk(A_ANA, 32'h55);
    rchk(A_CTRL, 32'h0);
    rchk(A_LSB, 32'h1);
    apb(1'b1, 12'h014, 32'hff);
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, A_LSB, 32'h0);
    wait_lvl(9'h19e, 400);
    chk(32'(o_level_code), 32'h19e);
    apb(1'b1, A_LSB, 32'h1);
    apb(1'b1, A_RAMP, 32'ha5);
    rchk(A_RAMP, 32'ha5);
    apb(1'b1, A_CTRL, 32'h40);
    repeat (2) @(negedge i_clk);
    chk(32'(o_play_slot), 32'h5);
    apb(1'b1, A_CTRL, 32'h0);
    repeat (2) @(negedge i_clk);
    chk(32'(o_play_slot), 32'h3);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 8; c++) begin
        apb(1'b1, A_CTRL, 32'(s << 3));
        apb(1'b1, A_ANA, 32'({c[2:0], c[1:0], 2'h1}));
        repeat (2) @(negedge i_clk);
        chk(32'(o_pwm_ratio), 32'(RAT[c] >> s));
        chk(32'(o_gain_sel), 32'(c[1:0]));
      end
    end
    apb(1'b1, A_RAMP, 32'he0);
    apb(1'b1, A_VOL, 32'hd8);
    step_gap(g);
    chk(32'(g), 32'd16);
    wait_lvl(9'h1b1, 600);
    @(negedge i_clk);
    chk(32'(o_level_qdb), 32'd18);
    apb(1'b1, A_RAMP, 32'ha0);
    apb(1'b1, A_VOL, 32'hcf);
    step_gap(g);
    chk(32'(g), 32'd128);
    wait_lvl(9'h19f, 3000);
    apb(1'b1, A_RAMP, 32'hf0);
    wait_lvl(9'h000, 8000);
    repeat (2) @(negedge i_clk);
    chk(32'(o_idle_audio), 32'h1);
    chk(32'(o_level_qdb), 32'hfffffe70);
    @(posedge i_clk) i_shutdown <= 1'b1;
    apb(1'b1, A_RAMP, 32'he0);
    repeat (20) @(negedge i_clk);
    chk(32'(o_idle_audio), 32'h1);
    @(posedge i_clk);
    i_shutdown <= 1'b0;
    i_sleep <= 1'b1;
    repeat (20) @(negedge i_clk);
    chk(32'(o_idle_audio), 32'h1);
    @(posedge i_clk) i_sleep <= 1'b0;
    wait_lvl(9'h19f, 8000);
    chk(32'(o_idle_audio), 32'h0);
    apb(1'b1, A_VOL, 32'h03);
    wait_lvl(9'h000, 8000);
    repeat (2) @(negedge i_clk);
    chk(32'(o_idle_audio), 32'h1);
    rchk(A_STAT, 32'h3800);
    @(posedge i_clk) i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(32'(o_level_code), 32'h19f);
    rchk(A_VOL, 32'hcf);
    report_and_stop();
  end
endmodule // testbench
